// [rtl/cgr_consts.vh]
// Constants for the clock generator SMBus configuration register bank
`ifndef CGR_CONSTS_VH
`define CGR_CONSTS_VH

// Register indices
`define CGR_IDX_IDENT_RV 8'h05
`define CGR_IDX_IDENT_FP 8'h06
`define CGR_IDX_RB_LEN 8'h07
`define CGR_IDX_DIV_PD 8'h0a
`define CGR_IDX_STOP 8'h0b
`define CGR_IDX_IMP_LO 8'h0c
`define CGR_IDX_IMP_HI 8'h0d
`define CGR_IDX_BIAS 8'h0e

// Reset values
`define CGR_RST_RB_LEN 5'h08
`define CGR_RST_KEEP 1'h1
`define CGR_RST_STOP 2'h0
`define CGR_RST_BIAS 6'h15

// Stopped-output encodings
`define CGR_STOP_LOWLOW 2'h0
`define CGR_STOP_HIZ 2'h1
`define CGR_STOP_HIGHLOW 2'h2
`define CGR_STOP_LOWHIGH 2'h3

// Bit positions inside the index-10 byte
`define CGR_BIT_DIVPROG 7
`define CGR_BIT_KEEP 6

// Slave addresses picked by the address strap
`define CGR_ADDR_STRAP0 7'h68
`define CGR_ADDR_STRAP1 7'h6a

// Bits per byte on the wire, and byte kinds while receiving
`define CGR_BITS_PER_BYTE 4'h8
`define CGR_LAST_TX_BIT 4'h7
`define CGR_RX_ADDR 2'h0
`define CGR_RX_INDEX 2'h1
`define CGR_RX_COUNT 2'h2
`define CGR_RX_DATA 2'h3

// Positions inside the pin synchroniser vector
`define CGR_PIN_SCL 0
`define CGR_PIN_SDA 1
`define CGR_PIN_STRAP 8
`define CGR_PIN_PD 9
`define CGR_PIN_W 10
`define CGR_PIN_OE_LO 2
`define CGR_PIN_OE_HI 7
// Filtered levels out of reset: bus idle high, enables released, strap low, no power-down
`define CGR_PIN_IDLE 10'h0ff

`endif

// [rtl/cgr_smbus_regs.v]
// SMBus slave with the configuration and identification bytes of a PCIe clock generator
// How it works
// - Index 5 is a read-only byte: revision code above, vendor code below, untouched by writes.
// - Index 6 is a read-only byte: two-bit family code above a six-bit part code.
// - The five low bits of index 7 set the block-read length and come up as eight.
// - Indices 4, 8 and 9 are reserved and steer nothing.
// - Bit 7 of index 10 enables divider programming; it resets to 0, or to 1 on the factory variant.
// - Bit 6 of index 10 keeps the configuration through power-down when 1, else restores defaults; resets to 1.
// - Bits 1:0 of index 11 pick the stopped level: 00 low/low, 01 both high-Z, 10 high/low, 11 low/high.
// - Indices 12 and 13 hold a two-bit impedance selector per output (00 33, 01 85, 10 100 ohm, 11 reserved).
// - Index 14 holds two-bit bias selectors for enable pins 0 to 2, each resetting to 01.
// - A block read returns the length byte first, then bytes from the written index on, until the host NACKs.
// - An output whose gate bit is low is forced to the stopped level from index 11 whatever its enable pin says.
`include "cgr_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module cgr_smbus_regs #(
  parameter FACTORY_VARIANT = 0,        // 1 makes divider programming come up enabled
  parameter [11:0] IMP_DEFAULT = 12'haaa, // Impedance selectors out of reset, two bits per output
  parameter [3:0] REV_CODE = 4'h2,      // Arbitrary revision code
  parameter [3:0] VENDOR_CODE = 4'h5,   // Arbitrary vendor code
  parameter [1:0] FAMILY_CODE = 2'h2,   // Arbitrary family code
  parameter [5:0] PART_CODE = 6'h15     // Arbitrary part code
) (
  input wire clock,                     // 20 MHz system clock
  input wire rst,                       // Synchronous reset, active high
  input wire scl_in,                    // SMBus clock pin level
  input wire sda_in,                    // SMBus data pin level
  output reg sda_out_r,                 // Data pin drive value, always low
  output reg sda_oe_r,                  // Data pin pulled low while high
  input wire addr_strap,                // Address select strap pin
  input wire pd_req,                    // Power-down request pin, active high
  input wire [5:0] oe_pin_n,            // Output enable pins, active low
  input wire [5:0] output_gate_bit,     // Per-output enable bits from the neighbouring byte
  output reg [5:0] dif_run_r,           // Output runs when high, else sits in stopped level
  output reg dif_stop_true_r,           // Stopped level of true leg
  output reg dif_stop_comp_r,           // Stopped level of complement leg
  output reg dif_stop_hiz_r,            // Both legs high impedance when stopped
  output reg divider_prog_en_r,         // Divider programming enabled
  output reg powerdown_config_keep_r,   // Keep configuration through power-down
  output reg [4:0] readback_length_r,   // Length byte sent first in a block read
  output reg [1:0] stopped_output_state_sel_r, // Stopped-level selector
  output reg [11:0] output_impedance_sel_r,    // Impedance selectors, output 0 in bits 1:0
  output reg [5:0] enable_pin_bias_sel_r       // Bias selectors, pin 0 in bits 1:0
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RX = 3'h1;
  localparam [2:0] S_ACK = 3'h2;
  localparam [2:0] S_TX = 3'h3;
  localparam [2:0] S_HACK = 3'h4;

  localparam RV_DIV = (FACTORY_VARIANT != 0) ? 1'b1 : 1'b0;

  // Pin synchroniser: three stages, a bit moves once stages two and three agree
  reg [`CGR_PIN_W-1:0] pin_s1_r;
  reg [`CGR_PIN_W-1:0] pin_s2_r;
  reg [`CGR_PIN_W-1:0] pin_s3_r;
  reg [`CGR_PIN_W-1:0] pin_f_r;
  wire [`CGR_PIN_W-1:0] pin_f_nxt;
  wire [`CGR_PIN_W-1:0] pin_raw;
  assign pin_raw = {pd_req, addr_strap, oe_pin_n, sda_in, scl_in};
  assign pin_f_nxt = (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));

  always @(posedge clock) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    if (rst) begin
      pin_f_r <= `CGR_PIN_IDLE;         // Idle levels, so no false bus edge or power-down after reset
    end else begin
      pin_f_r <= pin_f_nxt;
    end
  end

  // Bus events from the filtered levels
  wire scl_f = pin_f_r[`CGR_PIN_SCL];
  wire sda_f = pin_f_r[`CGR_PIN_SDA];
  wire scl_n = pin_f_nxt[`CGR_PIN_SCL];
  wire sda_n = pin_f_nxt[`CGR_PIN_SDA];
  wire scl_rise = ~scl_f & scl_n;
  wire scl_fall = scl_f & ~scl_n;
  wire bus_start = scl_f & scl_n & sda_f & ~sda_n;
  wire bus_stop = scl_f & scl_n & ~sda_f & sda_n;
  wire pd_f = pin_f_r[`CGR_PIN_PD];

  // Address strap is caught once, in the first cycle after reset release.
  // The filtered register still shows its reset level then, so the settled next value is taken.
  reg strap_done_r;
  reg strap_r;
  always @(posedge clock) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      strap_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      strap_r <= pin_f_nxt[`CGR_PIN_STRAP];
    end
  end
  wire [6:0] my_addr = strap_r ? `CGR_ADDR_STRAP1 : `CGR_ADDR_STRAP0;

  // Read view of the bank; anything unlisted reads zero
  reg [7:0] rd_byte;
  reg [7:0] idx_r;
  always @* begin
    case (idx_r)
      `CGR_IDX_IDENT_RV: rd_byte = {REV_CODE, VENDOR_CODE};
      `CGR_IDX_IDENT_FP: rd_byte = {FAMILY_CODE, PART_CODE};
      `CGR_IDX_RB_LEN: rd_byte = {3'h0, readback_length_r};
      `CGR_IDX_DIV_PD: rd_byte = {divider_prog_en_r, powerdown_config_keep_r, 6'h00};
      `CGR_IDX_STOP: rd_byte = {6'h00, stopped_output_state_sel_r};
      `CGR_IDX_IMP_LO: rd_byte = {output_impedance_sel_r[5:2], 2'h0, output_impedance_sel_r[1:0]};
      `CGR_IDX_IMP_HI: rd_byte = {output_impedance_sel_r[11:8], 2'h0, output_impedance_sel_r[7:6]};
      `CGR_IDX_BIAS: rd_byte = {enable_pin_bias_sel_r[5:2], 2'h0, enable_pin_bias_sel_r[1:0]};
      default: rd_byte = 8'h00;
    endcase
  end

  // Protocol state
  reg [2:0] state_r;
  reg [1:0] rx_kind_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg rw_r;
  reg host_ack_r;
  reg wr_en;                            // Data byte accepted this cycle

  always @(posedge clock) begin
    if (rst) begin
      state_r <= S_IDLE;
      rx_kind_r <= `CGR_RX_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      host_ack_r <= 1'b0;
      idx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else if (bus_stop) begin
      state_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      // Repeated start keeps the index for the following read
      state_r <= S_RX;
      rx_kind_r <= `CGR_RX_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        S_RX: begin
          if (scl_rise && bit_cnt_r != `CGR_BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sda_f};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == `CGR_BITS_PER_BYTE) begin
            case (rx_kind_r)
              `CGR_RX_ADDR: begin
                if (shift_r[7:1] == my_addr) begin
                  rw_r <= shift_r[0];
                  sda_oe_r <= 1'b1;
                  state_r <= S_ACK;
                end else begin
                  state_r <= S_IDLE;    // Not ours: stay off the bus until the next start
                end
              end
              `CGR_RX_INDEX: begin
                idx_r <= shift_r;
                rw_r <= 1'b0;
                rx_kind_r <= `CGR_RX_COUNT;
                sda_oe_r <= 1'b1;
                state_r <= S_ACK;
              end
              `CGR_RX_COUNT: begin
                // Byte count of a block write is acknowledged; data runs until stop
                rx_kind_r <= `CGR_RX_DATA;
                sda_oe_r <= 1'b1;
                state_r <= S_ACK;
              end
              default: begin
                idx_r <= idx_r + 8'h01;
                sda_oe_r <= 1'b1;
                state_r <= S_ACK;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rx_kind_r == `CGR_RX_ADDR && rw_r) begin
              // Length byte leads every block read
              sda_oe_r <= 1'b1;                                // Bit 7 of the length byte is zero
              shift_r <= {2'h0, readback_length_r, 1'b0};
              state_r <= S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              if (rx_kind_r == `CGR_RX_ADDR) begin
                rx_kind_r <= `CGR_RX_INDEX;
              end
              state_r <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == `CGR_LAST_TX_BIT) begin
              sda_oe_r <= 1'b0;
              state_r <= S_HACK;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              sda_oe_r <= ~shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
        end
        S_HACK: begin
          if (scl_rise) begin
            host_ack_r <= ~sda_f;
          end else if (scl_fall) begin
            if (host_ack_r) begin
              // Next byte from the index, which then steps on
              bit_cnt_r <= 4'h0;
              sda_oe_r <= ~rd_byte[7];
              shift_r <= {rd_byte[6:0], 1'b0};
              idx_r <= idx_r + 8'h01;
              state_r <= S_TX;
            end else begin
              state_r <= S_IDLE;        // Host NACK ends the read
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  always @* begin
    wr_en = ~rst & ~bus_stop & ~bus_start & (state_r == S_RX) & scl_fall
          & (bit_cnt_r == `CGR_BITS_PER_BYTE) & (rx_kind_r == `CGR_RX_DATA);
  end

  // Writable fields; reserved bits are dropped on write
  always @(posedge clock) begin
    if (rst || (pd_f && !powerdown_config_keep_r)) begin
      readback_length_r <= `CGR_RST_RB_LEN;
      divider_prog_en_r <= RV_DIV;
      powerdown_config_keep_r <= `CGR_RST_KEEP;
      stopped_output_state_sel_r <= `CGR_RST_STOP;
      output_impedance_sel_r <= IMP_DEFAULT;
      enable_pin_bias_sel_r <= `CGR_RST_BIAS;
    end else if (wr_en) begin
      case (idx_r)
        `CGR_IDX_RB_LEN: readback_length_r <= shift_r[4:0];
        `CGR_IDX_DIV_PD: begin
          divider_prog_en_r <= shift_r[`CGR_BIT_DIVPROG];
          powerdown_config_keep_r <= shift_r[`CGR_BIT_KEEP];
        end
        `CGR_IDX_STOP: stopped_output_state_sel_r <= shift_r[1:0];
        `CGR_IDX_IMP_LO: output_impedance_sel_r[5:0] <= {shift_r[7:4], shift_r[1:0]};
        `CGR_IDX_IMP_HI: output_impedance_sel_r[11:6] <= {shift_r[7:4], shift_r[1:0]};
        `CGR_IDX_BIAS: enable_pin_bias_sel_r <= {shift_r[7:4], shift_r[1:0]};
        default: begin
          // Identification and reserved indices take no write
        end
      endcase
    end
  end

  // Output gating and stopped level; registered so the pins never see decode glitches
  always @(posedge clock) begin
    if (rst) begin
      dif_run_r <= 6'h00;
      dif_stop_true_r <= 1'b0;
      dif_stop_comp_r <= 1'b0;
      dif_stop_hiz_r <= 1'b0;
    end else begin
      dif_run_r <= output_gate_bit & ~pin_f_r[`CGR_PIN_OE_HI:`CGR_PIN_OE_LO];
      dif_stop_true_r <= (stopped_output_state_sel_r == `CGR_STOP_HIGHLOW);
      dif_stop_comp_r <= (stopped_output_state_sel_r == `CGR_STOP_LOWHIGH);
      dif_stop_hiz_r <= (stopped_output_state_sel_r == `CGR_STOP_HIZ);
    end
  end

endmodule
`default_nettype wire

// [dv/cgr_regs_chk.sv]
// Port-level assertions for the SMBus configuration register bank
`timescale 1ns/10ps
`default_nettype none
module cgr_regs_chk #(
  parameter FACTORY_VARIANT = 0,
  parameter [11:0] IMP_DEFAULT = 12'haaa
) (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_out_r, // Data drive value
  input wire logic sda_oe_r, // Data pull-down
  input wire logic pd_req, // Power-down pin
  input wire logic [5:0] output_gate_bit, // Gate bits
  input wire logic [5:0] dif_run_r, // Run flags
  input wire logic dif_stop_true_r, // True stop level
  input wire logic dif_stop_comp_r, // Complement stop level
  input wire logic dif_stop_hiz_r, // Stop high-Z
  input wire logic divider_prog_en_r, // Divider enable
  input wire logic powerdown_config_keep_r, // Keep bit
  input wire logic [4:0] readback_length_r, // Read length
  input wire logic [1:0] stopped_output_state_sel_r, // Stop select
  input wire logic [11:0] output_impedance_sel_r, // Impedance
  input wire logic [5:0] enable_pin_bias_sel_r // Bias
);
  default clocking cb @(posedge clock); endclocking
  // Open drain: the pin value is only ever low, the enable does the work
  a_open_drain: assert property (disable iff (rst) sda_out_r == 1'b0) else $error("data drive not low");
  // Reset values show one edge after reset is seen
  a_reset_fields: assert property (rst |=> readback_length_r == 5'h08 && powerdown_config_keep_r
    && divider_prog_en_r == (FACTORY_VARIANT != 0) && stopped_output_state_sel_r == 2'h0) else $error("reset fields");
  a_reset_sels: assert property (rst |=> output_impedance_sel_r == IMP_DEFAULT
    && enable_pin_bias_sel_r == 6'h15 && dif_run_r == 6'h00) else $error("reset selectors");
  // Stop levels follow the selector one clock later
  a_stop_level: assert property (disable iff (rst) 1'b1 |=>
    dif_stop_true_r == ($past(stopped_output_state_sel_r) == 2'h2)
    && dif_stop_comp_r == ($past(stopped_output_state_sel_r) == 2'h3)) else $error("stop level decode");
  a_stop_hiz: assert property (disable iff (rst) $changed(stopped_output_state_sel_r) |=>
    dif_stop_hiz_r == (stopped_output_state_sel_r == 2'h1)) else $error("stop high-Z decode");
  // A low gate bit must hold its output stopped whatever the pin says
  a_gate_force: assert property (disable iff (rst) 1'b1 |=> (dif_run_r & ~$past(output_gate_bit)) == 6'h00)
    else $error("gated output runs");
  // A clearing power-down brings defaults back within the sync delay
  a_pd_restore: assert property (disable iff (rst) (pd_req && !powerdown_config_keep_r) ##1 pd_req[*7] |=>
    readback_length_r == 5'h08 && enable_pin_bias_sel_r == 6'h15 && powerdown_config_keep_r
    && output_impedance_sel_r == IMP_DEFAULT) else $error("power-down restore");
  // With the bus clock parked high no byte can land, so fields hold
  a_idle_hold: assert property (disable iff (rst) scl_in[*6] ##0 powerdown_config_keep_r |=>
    $stable(readback_length_r) && $stable(enable_pin_bias_sel_r)) else $error("field moved while idle");
  // Data may only move while the bus clock has been low a while
  a_oe_scl_low: assert property (disable iff (rst) $changed(sda_oe_r) |-> !scl_in && !$past(scl_in, 2))
    else $error("data pin moved with clock high");
endmodule
bind cgr_smbus_regs cgr_regs_chk #(.FACTORY_VARIANT(FACTORY_VARIANT), .IMP_DEFAULT(IMP_DEFAULT)) u_chk (
  .clock(clock), .rst(rst), .scl_in(scl_in), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r), .pd_req(pd_req),
  .output_gate_bit(output_gate_bit), .dif_run_r(dif_run_r), .dif_stop_true_r(dif_stop_true_r),
  .dif_stop_comp_r(dif_stop_comp_r), .dif_stop_hiz_r(dif_stop_hiz_r), .divider_prog_en_r(divider_prog_en_r),
  .powerdown_config_keep_r(powerdown_config_keep_r), .readback_length_r(readback_length_r),
  .stopped_output_state_sel_r(stopped_output_state_sel_r), .output_impedance_sel_r(output_impedance_sel_r),
  .enable_pin_bias_sel_r(enable_pin_bias_sel_r));
`default_nettype wire

// [dv/cgr_host_model.sv]
// Behavioural SMBus host issuing starts, stops and byte transfers
`timescale 1ns/10ps
`default_nettype none
module cgr_host_model (
  input wire logic clock, // System clock
  input wire logic sda, // Resolved data wire
  output var logic scl, // Bus clock, idles high
  output var logic sda_drv // Low pulls data down
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Ten clocks a phase, so data never moves in the step the clock does
  task automatic half();
    repeat (10) @(posedge clock);
    #1;
  endtask
  // Serves as repeated start too: data released before the clock rises
  task automatic start();
    half();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
  task automatic bit1(input logic tx, output logic rx);
    half();
    sda_drv = tx;
    half();
    scl = 1'b1;
    half();
    rx = sda;
    scl = 1'b0;
  endtask
  // Eight bits MSB first, then the ninth: nack high leaves data released
  task automatic xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx, output logic acked);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit1(tx[i], b);
      rx[i] = b;
    end
    bit1(nack, b);
    acked = ~b;
  endtask
endmodule
`default_nettype wire

// [dv/tb_clock_gen_smbus_config_regs.sv]
// Testbench for the clock generator SMBus configuration register bank
`timescale 1ns/10ps
`default_nettype none
module tb_clock_gen_smbus_config_regs;
  localparam logic [7:0] ID_RV = 8'h39; // Arbitrary revision and vendor codes
  localparam logic [7:0] ID_FP = 8'h6a; // Arbitrary family and part codes
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pd_req = 1'b0;
  logic [5:0] oe_pin_n = 6'h3f;
  logic [5:0] gate = 6'h00;
  logic [7:0] buf8 [0:15];
  wire scl, sda_drv, sda_oe, stop_t, stop_c, stop_z, div_en, keep;
  wire [5:0] run, bias;
  wire [4:0] len;
  wire [1:0] ssel;
  wire [11:0] imp;
  wire sda = sda_drv & ~sda_oe; // Pulled up unless a side pulls low
  int err_total = 0;
  int compares = 0;
  always #25 clock = ~clock;
  cgr_smbus_regs #(.REV_CODE(ID_RV[7:4]), .VENDOR_CODE(ID_RV[3:0]), .FAMILY_CODE(ID_FP[7:6]),
    .PART_CODE(ID_FP[5:0])) dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out_r(),
    .sda_oe_r(sda_oe), .addr_strap(1'b0), .pd_req(pd_req), .oe_pin_n(oe_pin_n), .output_gate_bit(gate),
    .dif_run_r(run), .dif_stop_true_r(stop_t), .dif_stop_comp_r(stop_c), .dif_stop_hiz_r(stop_z),
    .divider_prog_en_r(div_en), .powerdown_config_keep_r(keep), .readback_length_r(len),
    .stopped_output_state_sel_r(ssel), .output_impedance_sel_r(imp), .enable_pin_bias_sel_r(bias));
  cgr_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [87:0] v);
    for (int i = 0; i < 11; i++) buf8[i] = v[87 - 8 * i -: 8];
  endtask
  task automatic send(input logic [7:0] b);
    logic [7:0] rx;
    logic ak;
    host.xfer(b, 1'b1, rx, ak);
    check(12'(ak), 12'h001);
  endtask
  // Block write: index, count, then data to consecutive indices
  task automatic blk_wr(input logic [7:0] idx, input int n);
    host.start();
    send(8'hd0);
    send(idx);
    send(8'(n));
    for (int i = 0; i < n; i++) send(buf8[i]);
    host.stop();
  endtask
  // Block read: length byte first, then n bytes, the last refused
  task automatic blk_rd(input logic [7:0] idx, input int n, input logic [7:0] len_exp);
    logic [7:0] rx;
    logic ak;
    host.start();
    send(8'hd0);
    send(idx);
    host.start();
    send(8'hd1);
    host.xfer(8'hff, 1'b0, rx, ak);
    check(12'(rx), 12'(len_exp));
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hff, 1'(i == n - 1), rx, ak);
      check(12'(rx), 12'(buf8[i]));
    end
    host.stop();
  endtask
  // Defaults at the ports and in a read across reserved and fixed bytes
  task automatic t_defaults();
    check(12'({len, div_en, keep, ssel}), 12'h084);
    check(imp, 12'haaa);
    check(12'(bias), 12'h015);
    load({8'h00, ID_RV, ID_FP, 64'h08_00_00_40_00_a2_a2_51});
    blk_rd(8'h04, 11, 8'h08);
  endtask
  // Ones everywhere but indices 12 and 14: fixed and reserved places must not take them
  task automatic t_write_all();
    load(88'hff_ff_ff_ff_ff_ff_ff_ff_4e_ff_8e);
    blk_wr(8'h04, 11);
    check(12'({len, div_en, keep, ssel}), 12'h1ff);
    check(imp, 12'hfd2);
    check(12'(bias), 12'h022);
    load({8'h00, ID_RV, ID_FP, 64'h1f_00_00_c0_03_42_f3_82});
    blk_rd(8'h04, 11, 8'h1f);
  endtask
  task automatic t_stop_codes();
    for (int c = 0; c < 4; c++) begin
      buf8[0] = 8'(c);
      blk_wr(8'h0b, 1);
      check(12'({stop_t, stop_c, stop_z}), 12'({c == 2, c == 3, c == 1}));
    end
  endtask
  task automatic t_gate();
    gate = 6'h2d;
    oe_pin_n = 6'h00;
    repeat (8) @(posedge clock);
    #1;
    check(12'(run), 12'h02d);
    oe_pin_n = 6'h03;
    repeat (8) @(posedge clock);
    #1;
    check(12'(run), 12'h02c);
  endtask
  // Keeping power-down first, then a clearing one
  task automatic t_powerdown();
    pd_req = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    check(12'(len), 12'h01f);
    pd_req = 1'b0;
    buf8[0] = 8'h80;
    blk_wr(8'h0a, 1);
    check(12'({div_en, keep}), 12'h002);
    pd_req = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    check(12'({len, div_en, keep, ssel}), 12'h084);
    check(imp, 12'haaa);
    pd_req = 1'b0;
  endtask
  task automatic t_bad_addr();
    logic [7:0] rx;
    logic ak;
    host.start();
    host.xfer(8'hd4, 1'b1, rx, ak);
    check(12'(ak), 12'h000);
    host.stop();
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    t_defaults();
    t_bad_addr();
    t_write_all();
    t_stop_codes();
    t_gate();
    t_powerdown();
    final_report();
  end
  // Whole run needs about twenty thousand clocks
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
